// ===== rtl/dgpio_pkg.sv
// shared constants for the dual gpio port block
package dgpio_pkg;
  localparam int PORT_ONE_WIDTH = 6;
  localparam int PORT_TWO_WIDTH = 8;
  localparam int ANALOG_CFG_WIDTH = 4;
  localparam int TIMER_PIN_BIT = 4;
  localparam int PULLUP_N_BIT = 7;
  localparam int EDGE_SEL_BIT = 6;
  localparam int CHANGE_FLAG_BIT = 0;
  localparam int WATCH_LO = 4;
  localparam int WATCH_HI = 7;
  localparam int IRQ_PIN_BIT = 0;
  localparam int LVP_MODE_BIT = 3;
  localparam int LVP_CLOCK_BIT = 6;
  localparam int LVP_DATA_BIT = 7;
  localparam logic [5:0] DIR_ONE_RESET = 6'h3F;
  localparam logic [7:0] DIR_TWO_RESET = 8'hFF;
  localparam logic [3:0] ANALOG_CFG_RESET = 4'h0;
  localparam logic [3:0] ANALOG_CFG_DIGITAL = 4'h6;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
endpackage

// ===== rtl/dgpio_sync_if.sv
// carrier between the pin synchroniser and the port logic
interface dgpio_sync_if #(parameter int W = 14);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface

// ===== rtl/dgpio_sync.sv
// three-flop pin synchroniser with agreement filter
module dgpio_sync #(
  parameter int W = 14
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pins
  dgpio_sync_if.sync port
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] lvl;
  wire [W-1:0] agree = ~(s2 ^ s3);
  wire [W-1:0] next_lvl = (agree & s3) | (~agree & lvl);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      lvl <= '0;
    end else begin
      s1 <= port.raw;
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
    end
  end
  assign port.level = lvl;
endmodule

// ===== rtl/dgpio_top.sv
// dual gpio port with change detection, pull-ups and shared pin functions
module dgpio_top #(
  parameter int P1W = dgpio_pkg::PORT_ONE_WIDTH,
  parameter int P2W = dgpio_pkg::PORT_TWO_WIDTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // port one register access
  input wire logic port_one_data_wr,
  input wire logic port_one_data_rd,
  input wire logic [P1W-1:0] port_one_wdata,
  input wire logic [P1W-1:0] port_one_wmask,
  output logic [P1W-1:0] port_one_data,
  input wire logic port_one_direction_wr,
  input wire logic [P1W-1:0] port_one_direction_wdata,
  output logic [P1W-1:0] port_one_direction,
  input wire logic analog_config_two_wr,
  input wire logic [3:0] analog_config_two_wdata,
  output logic [3:0] analog_config_two,
  // port two register access
  input wire logic port_two_data_wr,
  input wire logic port_two_data_rd,
  input wire logic [P2W-1:0] port_two_wdata,
  input wire logic [P2W-1:0] port_two_wmask,
  output logic [P2W-1:0] port_two_data,
  input wire logic port_two_direction_wr,
  input wire logic [P2W-1:0] port_two_direction_wdata,
  output logic [P2W-1:0] port_two_direction,
  input wire logic option_wr,
  input wire logic [7:0] option_wdata,
  output logic [7:0] option_reg,
  // interrupt control bit zero
  input wire logic port_change_flag_clr,
  output logic port_change_flag,
  output logic wake_request,
  output logic ext_irq_event,
  // shared peripherals
  output logic timer_clock_shared_pin,
  input wire logic lvp_enable,
  output logic lvp_mode_pin,
  output logic lvp_clock_pin,
  output logic lvp_data_pin,
  input wire logic lvp_data_oe,
  input wire logic lvp_data_out,
  output logic [P1W-1:0] analog_select,
  // pins
  input wire logic [P1W-1:0] port_one_pin_in,
  output logic [P1W-1:0] port_one_pin_out,
  output logic [P1W-1:0] port_one_pin_oe,
  input wire logic [P2W-1:0] port_two_pin_in,
  output logic [P2W-1:0] port_two_pin_out,
  output logic [P2W-1:0] port_two_pin_oe,
  output logic [P2W-1:0] port_two_pullup_en
);
  // reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // analog config code to per-pin analog mask (pins 0,1,2,3,5)
  function automatic logic [5:0] dgpio_analog_mask(input logic [3:0] cfg);
    logic [5:0] m;
    m = 6'h00;
    case (cfg)
      4'h0, 4'h1, 4'h8: m = 6'h2F;
      4'h2, 4'h3, 4'hA: m = 6'h2F;
      4'h4, 4'h5, 4'hC: m = 6'h0B;
      4'h9: m = 6'h2F;
      4'hB, 4'hD: m = 6'h0F;
      4'hE, 4'hF: m = 6'h01;
      default: m = 6'h00;
    endcase
    return m;
  endfunction

  // synchronised pin levels
  dgpio_sync_if #(.W(P1W + P2W)) pins_if ();
  assign pins_if.raw = {port_two_pin_in, port_one_pin_in};
  dgpio_sync #(.W(P1W + P2W)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .port(pins_if.sync)
  );
  wire [P1W-1:0] p1_level = pins_if.level[P1W-1:0];
  wire [P2W-1:0] p2_level = pins_if.level[P1W+P2W-1:P1W];

  logic [P1W-1:0] latch_one;
  logic [P1W-1:0] dir_one;
  logic [P2W-1:0] latch_two;
  logic [P2W-1:0] dir_two;
  logic [3:0] acfg;
  logic [7:0] opt;
  logic [3:0] ref_watch;
  logic flag;
  logic irq_prev;

  wire [P1W-1:0] amask = P1W'(dgpio_analog_mask(acfg));
  wire [P1W-1:0] p1_read = p1_level & ~amask;
  wire [P1W-1:0] next_latch_one =
    (p1_read & ~port_one_wmask) | (port_one_wdata & port_one_wmask);
  wire [P2W-1:0] next_latch_two =
    (p2_level & ~port_two_wmask) | (port_two_wdata & port_two_wmask);
  wire p2_access = port_two_data_rd | port_two_data_wr;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latch_one <= '0;
      dir_one <= dgpio_pkg::DIR_ONE_RESET;
      acfg <= dgpio_pkg::ANALOG_CFG_RESET;
    end else begin
      if (port_one_data_wr) latch_one <= next_latch_one;
      if (port_one_direction_wr) dir_one <= port_one_direction_wdata;
      if (analog_config_two_wr) acfg <= analog_config_two_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latch_two <= '0;
      dir_two <= dgpio_pkg::DIR_TWO_RESET;
      opt <= dgpio_pkg::OPTION_RESET;
    end else begin
      if (port_two_data_wr) latch_two <= next_latch_two;
      if (port_two_direction_wr) dir_two <= port_two_direction_wdata;
      if (option_wr) opt <= option_wdata;
    end
  end

  // port one drivers
  wire timer_bit_drive = ~dir_one[dgpio_pkg::TIMER_PIN_BIT]
                         & ~latch_one[dgpio_pkg::TIMER_PIN_BIT];
  genvar gi;
  generate
    for (gi = 0; gi < P1W; gi++) begin : g_one
      if (gi == dgpio_pkg::TIMER_PIN_BIT) begin : g_od
        assign port_one_pin_out[gi] = 1'b0;
        assign port_one_pin_oe[gi] = timer_bit_drive;
      end else begin : g_pp
        assign port_one_pin_out[gi] = latch_one[gi];
        assign port_one_pin_oe[gi] = ~dir_one[gi];
      end
    end
  endgenerate
  assign timer_clock_shared_pin = p1_level[dgpio_pkg::TIMER_PIN_BIT];
  assign analog_select = amask;

  // port two drivers with programming override
  logic [P2W-1:0] lvp_oe_mask;
  logic [P2W-1:0] lvp_out;
  always_comb begin
    lvp_oe_mask = '0;
    lvp_out = '0;
    lvp_oe_mask[dgpio_pkg::LVP_MODE_BIT] = lvp_enable;
    lvp_oe_mask[dgpio_pkg::LVP_CLOCK_BIT] = lvp_enable;
    lvp_oe_mask[dgpio_pkg::LVP_DATA_BIT] = lvp_enable;
    lvp_out[dgpio_pkg::LVP_DATA_BIT] = lvp_data_out;
  end
  wire [P2W-1:0] lvp_drive = {P2W{1'b0}} | (lvp_oe_mask & {P2W{lvp_data_oe}}
    & (P2W'(1) << dgpio_pkg::LVP_DATA_BIT));
  // peripheral owns the pin: gpio drive is replaced, not merged
  assign port_two_pin_out = (lvp_oe_mask & lvp_out) | (~lvp_oe_mask & latch_two);
  assign port_two_pin_oe = (lvp_oe_mask & lvp_drive) | (~lvp_oe_mask & ~dir_two);
  assign port_two_pullup_en = {P2W{~opt[dgpio_pkg::PULLUP_N_BIT]}} & dir_two;
  assign lvp_mode_pin = p2_level[dgpio_pkg::LVP_MODE_BIT];
  assign lvp_clock_pin = p2_level[dgpio_pkg::LVP_CLOCK_BIT];
  assign lvp_data_pin = p2_level[dgpio_pkg::LVP_DATA_BIT];

  // change detection on the watched upper pins
  wire [3:0] watch_lvl = p2_level[dgpio_pkg::WATCH_HI:dgpio_pkg::WATCH_LO];
  wire [3:0] watch_in = dir_two[dgpio_pkg::WATCH_HI:dgpio_pkg::WATCH_LO];
  wire [3:0] mismatch = (watch_lvl ^ ref_watch) & watch_in;
  wire any_mismatch = |mismatch;
  // an access reloads the reference, so the mismatch ends next cycle
  wire next_flag = any_mismatch | (flag & ~port_change_flag_clr);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_watch <= '0;
      flag <= 1'b0;
    end else begin
      if (p2_access) ref_watch <= watch_lvl;
      flag <= next_flag;
    end
  end

  // external interrupt edge on bit zero
  wire irq_lvl = p2_level[dgpio_pkg::IRQ_PIN_BIT];
  wire irq_rise = irq_lvl & ~irq_prev;
  wire irq_fall = ~irq_lvl & irq_prev;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_prev <= 1'b0;
      ext_irq_event <= 1'b0;
    end else begin
      irq_prev <= irq_lvl;
      ext_irq_event <= opt[dgpio_pkg::EDGE_SEL_BIT] ? irq_rise : irq_fall;
    end
  end

  assign port_change_flag = flag;
  assign wake_request = flag;
  assign port_one_data = p1_read;
  assign port_two_data = p2_level;
  assign port_one_direction = dir_one;
  assign port_two_direction = dir_two;
  assign analog_config_two = acfg;
  assign option_reg = opt;

  chk_flag_follows_mismatch: assert property (@(posedge clock) disable iff (!rst_n)
    any_mismatch |=> flag) else $error("change flag missed a mismatch");
  chk_access_ends_mismatch: assert property (@(posedge clock) disable iff (!rst_n)
    (p2_access && !port_two_direction_wr && $stable(watch_lvl)[*1]) ##1 $stable(watch_lvl)
    |-> mismatch == 4'h0) else $error("access did not end mismatch");
  chk_output_excluded: assert property (@(posedge clock) disable iff (!rst_n)
    (watch_in == 4'h0) |-> !any_mismatch) else $error("output pin compared");
  chk_pullup_off_out: assert property (@(posedge clock) disable iff (!rst_n)
    (port_two_pullup_en & ~port_two_direction) == '0) else $error("pullup on output");
  chk_pullup_global: assert property (@(posedge clock) disable iff (!rst_n)
    opt[dgpio_pkg::PULLUP_N_BIT] |-> port_two_pullup_en == '0) else $error("pullup on");
  chk_timer_open_drain: assert property (@(posedge clock) disable iff (!rst_n)
    port_one_pin_out[dgpio_pkg::TIMER_PIN_BIT] == 1'b0) else $error("open drain high");
  chk_analog_reads_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (port_one_data & amask) == '0) else $error("analog pin read nonzero");
  chk_write_latch_one: assert property (@(posedge clock) disable iff (!rst_n)
    port_one_data_wr |=> latch_one == $past(next_latch_one)) else $error("latch one");
  chk_drive_latch: assert property (@(posedge clock) disable iff (!rst_n)
    !lvp_enable |-> (port_two_pin_oe == ~port_two_direction)) else $error("bad drive");
  chk_ext_edge: assert property (@(posedge clock) disable iff (!rst_n)
    (irq_rise && opt[dgpio_pkg::EDGE_SEL_BIT]) |=> ext_irq_event) else $error("edge lost");
endmodule

// ===== verification/dgpio_pin_model.sv
// far-side pin model: resolves driver, outside source, pull-up or float
module dgpio_pin_model #(
  parameter int W = 8
) (
  // clock
  input wire logic clock,
  // device side
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] pullup_en,
  // outside sources
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  // resolved level
  output logic [W-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] flt = '0;
  // a floating pin toggles so it never settles on a lucky value
  always @(posedge clock) flt <= ~flt;
  // device driver wins, else outside source, else pull-up, else float
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pullup_en | flt));
endmodule

// ===== verification/test_dgpio_top.sv
// self-checking bench for the dual gpio port block
module test_dgpio_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] stb = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] wm = 8'h00;
  logic [5:0] e1v = 6'h3F;
  logic [5:0] e1e = 6'h3F;
  logic [7:0] e2v = 8'h00;
  logic [7:0] e2e = 8'hFF;
  logic [5:0] p1d, p1r, p1in, p1out, p1oe, asel;
  logic [7:0] p2d, p2r, opt, p2in, p2out, p2oe, p2pu;
  logic [3:0] acfg;
  logic flag, wake, irq, tclk, lm, lc, ld;
  logic lve = 1'b0;
  logic lvo = 1'b0;
  logic lvd = 1'b0;
  int fail_count = 0;
  int comparisons = 0;
  int n;
  initial forever #2.5 clock = ~clock;
  dgpio_top dut (.clock(clock), .arst_n(arst_n),
    .port_one_data_wr(stb[0]), .port_one_data_rd(1'b0), .port_one_wdata(wd[5:0]),
    .port_one_wmask(wm[5:0]), .port_one_data(p1d), .port_one_direction_wr(stb[1]),
    .port_one_direction_wdata(wd[5:0]), .port_one_direction(p1r),
    .analog_config_two_wr(stb[2]), .analog_config_two_wdata(wd[3:0]),
    .analog_config_two(acfg), .port_two_data_wr(stb[3]), .port_two_data_rd(stb[6]),
    .port_two_wdata(wd), .port_two_wmask(wm), .port_two_data(p2d),
    .port_two_direction_wr(stb[4]), .port_two_direction_wdata(wd),
    .port_two_direction(p2r), .option_wr(stb[5]), .option_wdata(wd), .option_reg(opt),
    .port_change_flag_clr(stb[7]), .port_change_flag(flag), .wake_request(wake),
    .ext_irq_event(irq), .timer_clock_shared_pin(tclk), .lvp_enable(lve),
    .lvp_mode_pin(lm), .lvp_clock_pin(lc), .lvp_data_pin(ld), .lvp_data_oe(lvo),
    .lvp_data_out(lvd), .analog_select(asel), .port_one_pin_in(p1in),
    .port_one_pin_out(p1out), .port_one_pin_oe(p1oe), .port_two_pin_in(p2in),
    .port_two_pin_out(p2out), .port_two_pin_oe(p2oe), .port_two_pullup_en(p2pu));
  dgpio_pin_model #(.W(6)) pins_one (.clock(clock), .pin_out(p1out), .pin_oe(p1oe),
    .pullup_en(6'h00), .ext_val(e1v), .ext_en(e1e), .pin_in(p1in));
  dgpio_pin_model #(.W(8)) pins_two (.clock(clock), .pin_out(p2out), .pin_oe(p2oe),
    .pullup_en(p2pu), .ext_val(e2v), .ext_en(e2e), .pin_in(p2in));
  task automatic ck(input string nm, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask
  // one strobe per call; k picks the strobe bit
  task automatic go(input int k, input logic [7:0] d, input logic [7:0] m);
    @(posedge clock);
    wd <= d;
    wm <= m;
    stb <= 8'h01 << k;
    @(posedge clock);
    stb <= 8'h00;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic test_done();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait for the change flag; a timeout ends the run
  task automatic wait_flag();
    for (n = 0; n < 12 && flag !== 1'b1; n++) idle(1);
    ck("flag_wait", {7'h00, flag}, 8'h01);
    if (flag !== 1'b1) test_done();
  endtask
  initial begin
    idle(5);
    arst_n <= 1'b1;
    idle(6);
    ck("dir_one_rst", {2'h0, p1r}, 8'h3F);
    ck("dir_two_rst", p2r, 8'hFF);
    ck("oe_one_rst", {2'h0, p1oe}, 8'h00);
    ck("option_rst", opt, 8'hFF);
    ck("pullup_rst", p2pu, 8'h00);
    ck("analog_rd", {2'h0, p1d}, 8'h10);
    $display("test reset done");
    go(2, 8'h06, 8'h00);
    idle(6);
    ck("digital_rd", {2'h0, p1d}, 8'h3F);
    e1e <= 6'h0F;
    go(1, 8'h0F, 8'h00);
    go(0, 8'h00, 8'h3F);
    idle(6);
    ck("oe_one_out", {2'h0, p1oe}, 8'h30);
    ck("pins_low", {2'h0, p1d}, 8'h0F);
    go(0, 8'h30, 8'h30);
    idle(6);
    ck("open_drain", {2'h0, p1oe}, 8'h20);
    ck("timer_pin", {7'h00, tclk}, 8'h00);
    ck("rmw_one", {2'h0, p1out[5], 5'h00}, 8'h20);
    $display("test port one done");
    go(5, 8'h7F, 8'h00);
    go(4, 8'hF0, 8'h00);
    idle(2);
    ck("pullup_in", p2pu, 8'hF0);
    go(4, 8'hFF, 8'h00);
    go(6, 8'h00, 8'h00);
    idle(6);
    ck("two_rd", p2d, 8'h00);
    go(7, 8'h00, 8'h00);
    idle(2);
    e2v <= 8'h80;
    wait_flag();
    ck("wake", {7'h00, wake}, 8'h01);
    go(7, 8'h00, 8'h00);
    idle(2);
    ck("set_wins", {7'h00, flag}, 8'h01);
    go(6, 8'h00, 8'h00);
    idle(2);
    go(7, 8'h00, 8'h00);
    idle(2);
    ck("cleared", {7'h00, flag}, 8'h00);
    e2v <= 8'h8F;
    idle(8);
    ck("low_ignored", {7'h00, flag}, 8'h00);
    e2e <= 8'h7F;
    go(4, 8'h7F, 8'h00);
    go(3, 8'h00, 8'h80);
    idle(8);
    ck("out_excluded", {7'h00, flag}, 8'h00);
    ck("rmw_two", p2out, 8'h0F);
    $display("test change done");
    @(posedge clock);
    lve <= 1'b1;
    lvo <= 1'b1;
    lvd <= 1'b1;
    idle(6);
    ck("lvp_oe", p2oe, 8'h80);
    ck("lvp_out", p2out, 8'h87);
    ck("lvp_data_in", {7'h00, ld}, 8'h01);
    @(posedge clock);
    lve <= 1'b0;
    lvo <= 1'b0;
    lvd <= 1'b0;
    idle(6);
    ck("lvp_released", p2out, 8'h0F);
    $display("test programming pins done");
    e2v <= 8'h0E;
    idle(6);
    n = 0;
    e2v <= 8'h0F;
    repeat (8) begin
      idle(1);
      if (irq === 1'b1) n++;
    end
    ck("rise_pulses", n[7:0], 8'h01);
    e2v <= 8'h0E;
    n = 0;
    repeat (8) begin
      idle(1);
      if (irq === 1'b1) n++;
    end
    ck("fall_pulses", n[7:0], 8'h00);
    $display("test irq done");
    test_done();
  end
endmodule
